// file: shared/srq_pkg.sv
// package: constants and carrier types for the sdram read queue buffers
// assumes: one clock, registers reached over a plain strobe port
// ==========================================================================
package srq_pkg;
  localparam logic [23:0] CFG_OFFSET  = 24'h3A0210;
  localparam int          EN_BIT      = 0;
  localparam int          AREA13_BIT  = 1;
  localparam int          AREA14_BIT  = 2;
  localparam int          FAST_BIT    = 3;
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [3:0]  CFG_MASK    = 4'hF;
  localparam int          SLOT_WORDS  = 8;
  localparam int          DBUF_WORDS  = 2;

  typedef enum logic [4:0] {
    SRQ_IDLE  = 5'b00001,
    SRQ_DFILL = 5'b00010,
    SRQ_IFILL = 5'b00100,
    SRQ_WRITE = 5'b01000,
    SRQ_DONE  = 5'b10000
  } srq_state_t;

  // processor side request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ifetch;
    logic [24:1] addr;
    logic [15:0] wdata;
  } srq_req_t;

  // memory side request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [3:0]  len;
    logic [24:1] addr;
    logic [15:0] wdata;
  } srq_mreq_t;
endpackage

// file: design/srq_top.sv
// module: read queue buffers between bus control unit and memory ctrl block
// assumes: requests held stable until ack; memory returns beats in order
`timescale 1ns/1ps
module srq_top (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [23:0]      reg_addr_i,
  input  wire logic [15:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [15:0]      reg_rdata_o,
  input  wire srq_pkg::srq_req_t cpu_req_i,
  output logic      [15:0]      cpu_rdata_o,
  output logic                  cpu_wait_o,
  output logic                  cpu_ack_o,
  output srq_pkg::srq_mreq_t    mem_req_o,
  input  wire logic [15:0]      mem_rdata_i,
  input  wire logic             mem_rvalid_i,
  input  wire logic             mem_wdone_i,
  output logic                  fast_access_select_o,
  output logic                  upper_area_memory_select_o,
  output logic                  lower_area_memory_select_o
);
  import srq_pkg::*;

  // ========================================================================
  // configuration register
  logic [3:0]  cfg;
  logic        prefetch_buffer_enable;
  assign prefetch_buffer_enable = cfg[EN_BIT];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg <= CFG_RESET[3:0];
    end else if (reg_wr_i && reg_addr_i == CFG_OFFSET) begin
      cfg <= reg_wdata_i[3:0] & CFG_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i && reg_addr_i == CFG_OFFSET) begin
      reg_rdata_o <= {12'h000, cfg};
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fast_access_select_o       <= 1'b0;
      upper_area_memory_select_o <= 1'b0;
      lower_area_memory_select_o <= 1'b0;
    end else begin
      fast_access_select_o       <= cfg[FAST_BIT];
      upper_area_memory_select_o <= cfg[AREA14_BIT];
      lower_area_memory_select_o <= cfg[AREA13_BIT];
    end
  end

  // ========================================================================
  // storage and tags
  logic [15:0] read_data_buffer [DBUF_WORDS];
  logic [15:0] instruction_prefetch_buffer [2][SLOT_WORDS];
  logic [24:2] dtag;
  logic        dvalid;
  logic [24:4] itag [2];
  logic [1:0]  ivalid;
  logic        next_slot;

  function automatic logic in_slot(input logic [24:4] tag, input logic v,
                                   input logic [24:1] a);
    return v && tag == a[24:4];
  endfunction

  // ========================================================================
  // hit decode
  srq_req_t    rq;
  logic        ihit0;
  logic        ihit1;
  logic        ihit;
  logic        dhit;
  logic        use_iq;
  logic        corner;
  // request still stands in its ack cycle: do not take it twice
  always_comb begin
    rq = cpu_req_i;
    if (cpu_ack_o) begin
      rq = '0;
    end
  end
  assign ihit0  = in_slot(itag[0], ivalid[0], rq.addr);
  assign ihit1  = in_slot(itag[1], ivalid[1], rq.addr);
  assign ihit   = ihit0 | ihit1;
  assign dhit   = dvalid && dtag == rq.addr[24:2];
  assign corner = rq.addr[3:2] == 2'b11;
  // prefetch off: every read goes via read buffer
  assign use_iq = prefetch_buffer_enable && rq.ifetch && (ihit || !corner);

  // ========================================================================
  // sequencer
  srq_state_t  state;
  logic [3:0]  beat;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state       <= SRQ_IDLE;
      beat        <= 4'h0;
      cpu_wait_o  <= 1'b0;
      cpu_ack_o   <= 1'b0;
      cpu_rdata_o <= 16'h0000;
      mem_req_o   <= '0;
    end else begin
      cpu_ack_o <= 1'b0;
      case (state)
        SRQ_IDLE: begin
          mem_req_o <= '0;
          if (rq.wr) begin
            cpu_wait_o      <= 1'b1;
            mem_req_o.wr    <= 1'b1;
            mem_req_o.addr  <= rq.addr;
            mem_req_o.wdata <= rq.wdata;
            state           <= SRQ_WRITE;
          end else if (rq.rd && use_iq && ihit) begin
            cpu_rdata_o <= instruction_prefetch_buffer[ihit1][rq.addr[3:1]];
            cpu_ack_o   <= 1'b1;
          end else if (rq.rd && !use_iq && dhit) begin
            cpu_rdata_o <= read_data_buffer[rq.addr[1]];
            cpu_ack_o   <= 1'b1;
          end else if (rq.rd && use_iq) begin
            cpu_wait_o     <= 1'b1;
            mem_req_o.rd   <= 1'b1;
            mem_req_o.len  <= 4'(SLOT_WORDS);
            mem_req_o.addr <= {rq.addr[24:4], 3'b000};
            beat           <= 4'h0;
            state          <= SRQ_IFILL;
          end else if (rq.rd) begin
            cpu_wait_o     <= 1'b1;
            mem_req_o.rd   <= 1'b1;
            mem_req_o.len  <= 4'(DBUF_WORDS);
            mem_req_o.addr <= {rq.addr[24:2], 1'b0};
            beat           <= 4'h0;
            state          <= SRQ_DFILL;
          end
        end
        SRQ_DFILL: begin
          mem_req_o.rd <= 1'b0;
          if (mem_rvalid_i) begin
            beat <= beat + 4'h1;
            if (beat == 4'(DBUF_WORDS - 1)) begin
              state <= SRQ_DONE;
            end
          end
        end
        SRQ_IFILL: begin
          mem_req_o.rd <= 1'b0;
          if (mem_rvalid_i) begin
            beat <= beat + 4'h1;
            if (beat == 4'(SLOT_WORDS - 1)) begin
              state <= SRQ_DONE;
            end
          end
        end
        SRQ_WRITE: begin
          mem_req_o.wr <= 1'b0;
          if (mem_wdone_i) begin
            cpu_wait_o <= 1'b0;
            cpu_ack_o  <= 1'b1;
            state      <= SRQ_IDLE;
          end
        end
        SRQ_DONE: begin
          cpu_wait_o <= 1'b0;
          state      <= SRQ_IDLE;
        end
        default: begin
          state <= SRQ_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // read buffer fill, always active
  always_ff @(posedge sys_clk_i) begin
    if (state == SRQ_DFILL && mem_rvalid_i) begin
      read_data_buffer[beat[0]] <= mem_rdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dvalid <= 1'b0;
      dtag   <= '0;
    end else if (state == SRQ_IDLE && rq.wr && dhit) begin
      dvalid <= 1'b0;
    end else if (state == SRQ_IDLE && rq.rd && !use_iq && !dhit) begin
      dvalid <= 1'b0;
      dtag   <= rq.addr[24:2];
    end else if (state == SRQ_DFILL && mem_rvalid_i && beat == 4'(DBUF_WORDS - 1)) begin
      dvalid <= 1'b1;
    end
  end

  // ========================================================================
  // prefetch slot fill, slots alternate
  always_ff @(posedge sys_clk_i) begin
    if (state == SRQ_IFILL && mem_rvalid_i) begin
      instruction_prefetch_buffer[next_slot][beat[2:0]] <= mem_rdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ivalid    <= 2'b00;
      itag[0]   <= '0;
      itag[1]   <= '0;
      next_slot <= 1'b0;
    end else if (state == SRQ_IDLE && rq.wr) begin
      if (ihit0) begin
        ivalid[0] <= 1'b0;
      end
      if (ihit1) begin
        ivalid[1] <= 1'b0;
      end
    end else if (state == SRQ_IDLE && rq.rd && use_iq && !ihit) begin
      ivalid[next_slot] <= 1'b0;
      itag[next_slot]   <= rq.addr[24:4];
    end else if (state == SRQ_IFILL && mem_rvalid_i && beat == 4'(SLOT_WORDS - 1)) begin
      ivalid[next_slot] <= 1'b1;
      next_slot         <= ~next_slot;
    end
  end

  // ========================================================================
  // checks
  sequence miss_start_s;
    state == SRQ_IDLE && rq.rd && !rq.wr && !(use_iq ? ihit : dhit);
  endsequence

  sequence wait_up_s;
    cpu_wait_o && mem_req_o.rd;
  endsequence

  miss_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    miss_start_s |=> wait_up_s)
    else $error("miss did not raise wait and memory read");
  hit_nowait_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IDLE && rq.rd && !rq.wr && (use_iq ? ihit : dhit)
    |=> cpu_ack_o && !cpu_wait_o && !mem_req_o.rd)
    else $error("hit caused wait or memory access");
  held_noread_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IDLE && rq.rd && !rq.wr && !use_iq && dhit
    |=> cpu_rdata_o == read_data_buffer[$past(rq.addr[1])])
    else $error("buffered value not returned");
  write_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_WRITE && !mem_wdone_i |=> cpu_wait_o)
    else $error("wait dropped before write done");
  write_flush_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IDLE && rq.wr && dhit |=> !dvalid)
    else $error("write did not flush read buffer");
  slot_flush_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IDLE && rq.wr && ihit0 |=> !ivalid[0])
    else $error("write did not clear slot entry");
  slot_align_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IFILL && $past(state) == SRQ_IDLE
    |-> mem_req_o.addr[3:1] == 3'b000 && mem_req_o.len == 4'(SLOT_WORDS))
    else $error("slot fill not aligned or not eight long");
  burst_align_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_DFILL && $past(state) == SRQ_IDLE
    |-> !mem_req_o.addr[1] && mem_req_o.len == 4'(DBUF_WORDS))
    else $error("burst not word aligned");
  off_route_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !prefetch_buffer_enable |-> state != SRQ_IFILL)
    else $error("prefetch slot used while disabled");
  corner_route_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IDLE && rq.rd && !rq.wr && rq.ifetch && prefetch_buffer_enable
    && corner && !ihit && !dhit |=> state == SRQ_DFILL)
    else $error("corner fetch missed read buffer");
  slot_swap_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_IFILL && mem_rvalid_i && beat == 4'(SLOT_WORDS - 1)
    |=> next_slot != $past(next_slot))
    else $error("slots did not alternate");
  dvalid_fill_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_DFILL && mem_rvalid_i && beat == 4'(DBUF_WORDS - 1)
    |=> dvalid && state == SRQ_DONE)
    else $error("read buffer not valid after last beat");
  fill_done_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_DONE |=> !cpu_wait_o && state == SRQ_IDLE)
    else $error("wait not released after fill");
  write_done_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_WRITE && mem_wdone_i |=> !cpu_wait_o && cpu_ack_o)
    else $error("write completion not acknowledged");
  write_noread_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == SRQ_WRITE |-> !mem_req_o.rd)
    else $error("memory read issued during write");
  ack_single_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cpu_ack_o |=> !cpu_ack_o)
    else $error("held request taken twice");
endmodule

// file: testbench/srq_mem_model.sv
// model: memory ctrl block answering bursts and writes
// assumes: one request at a time; read pulses carry base address and length
`timescale 1ns/1ps
module srq_mem_model
  import srq_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               rstn_i,
  input  wire srq_pkg::srq_mreq_t mem_req_i,
  input  wire logic               slow_i,
  output logic      [15:0]        mem_rdata_o,
  output logic                    mem_rvalid_o,
  output logic                    mem_wdone_o,
  output int                      rd_count_o,
  output logic      [3:0]         last_len_o,
  output logic      [24:1]        last_addr_o
);
  logic [15:0] wmem [logic [24:1]];
  srq_mreq_t   r;
  logic [24:1] ai;
  // ==========================================================================
  // request handling
  initial begin
    mem_rdata_o  = 16'h0000;
    mem_rvalid_o = 1'b0;
    mem_wdone_o  = 1'b0;
    rd_count_o   = 0;
    last_len_o   = 4'h0;
    last_addr_o  = '0;
    forever begin
      @(posedge sys_clk_i);
      r = mem_req_i;
      if (rstn_i && r.rd === 1'b1) begin
        rd_count_o++;
        last_len_o  = r.len;
        last_addr_o = r.addr;
        repeat (slow_i ? 4 : 1) @(posedge sys_clk_i);
        // beats in address order
        for (int i = 0; i < int'(r.len); i++) begin
          ai = r.addr + 24'(i);
          mem_rvalid_o <= 1'b1;
          mem_rdata_o  <= wmem.exists(ai) ? wmem[ai] : (ai[16:1] ^ 16'h5A3C);
          @(posedge sys_clk_i);
        end
        mem_rvalid_o <= 1'b0;
        mem_rdata_o  <= ~mem_rdata_o;
      end else if (rstn_i && r.wr === 1'b1) begin
        repeat (slow_i ? 4 : 1) @(posedge sys_clk_i);
        wmem[r.addr] = r.wdata;
        mem_wdone_o <= 1'b1;
        @(posedge sys_clk_i);
        mem_wdone_o <= 1'b0;
      end
    end
  end
endmodule

// file: testbench/tb_sdram_read_queue_buffers.sv
// bench: scenarios for the read queue buffers
// assumes: srq_pkg and srq_mem_model compiled first
`timescale 1ns/1ps
module tb_sdram_read_queue_buffers;
  import srq_pkg::*;
  logic        sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, slow;
  logic [23:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, cpu_rdata_o, mem_rdata_i, q;
  logic        cpu_wait_o, cpu_ack_o, mem_rvalid_i, mem_wdone_i, fas, uas, las, wt;
  srq_req_t    cpu_req_i;
  srq_mreq_t   mem_req_o;
  int          n_errors, n_compared, n_rd, n;
  logic [3:0]  last_len;
  logic [24:1] last_addr;
  srq_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
    .cpu_wait_o(cpu_wait_o), .cpu_ack_o(cpu_ack_o), .mem_req_o(mem_req_o),
    .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i), .mem_wdone_i(mem_wdone_i),
    .fast_access_select_o(fas), .upper_area_memory_select_o(uas),
    .lower_area_memory_select_o(las));
  srq_mem_model mem (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_o),
    .slow_i(slow), .mem_rdata_o(mem_rdata_i), .mem_rvalid_o(mem_rvalid_i),
    .mem_wdone_o(mem_wdone_i), .rd_count_o(n_rd), .last_len_o(last_len),
    .last_addr_o(last_addr));
  // ==========================================================================
  // helpers
  task automatic final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] pat(input logic [24:0] b);
    return b[16:1] ^ 16'h5A3C;
  endfunction
  task automatic reg_op(input logic w, input logic [23:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge sys_clk_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    @(posedge sys_clk_i);
    q = reg_rdata_o;
  endtask
  task automatic cpu_op(input logic w, input logic f, input logic [24:0] b, input logic [15:0] d);
    int k;
    n = 0;
    wt = 1'b0;
    @(posedge sys_clk_i);
    cpu_req_i <= '{!w, w, f, b[24:1], d};
    do begin
      @(posedge sys_clk_i);
      n++;
      wt = wt | cpu_wait_o;
    end while (cpu_ack_o !== 1'b1 && n < 300);
    chk("ack", cpu_ack_o, 1'b1);
    q = cpu_rdata_o;
    cpu_req_i <= '0;
    k = 0;
    for (int j = 0; j < 60 && k < 3; j++) begin
      @(posedge sys_clk_i);
      k = (cpu_wait_o === 1'b0) ? k + 1 : 0;
    end
    chk("idle", k, 3);
  endtask
  task automatic rd(input logic f, input logic [24:0] b, input logic [15:0] e,
                    input logic miss, input logic [3:0] len);
    int c0;
    c0 = n_rd;
    cpu_op(1'b0, f, b, 16'h0000);
    chk("rdata", q, e);
    chk("wait", wt, miss);
    chk("mem_reads", n_rd - c0, miss);
    if (miss) begin
      chk("len", last_len, len);
      chk("addr", last_addr, b[24:1] & ((len == 4'h8) ? ~24'h7 : ~24'h1));
    end else
      chk("hit_latency", n, 2);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    reg_op(1'b0, CFG_OFFSET, 16'h0000);
    chk("cfg_reset", q, 16'h0000);
    chk("wait_reset", cpu_wait_o, 1'b0);
  endtask
  task automatic t_data;
    rd(1'b0, 25'h000100, pat(25'h000100), 1'b1, 4'h2);
    rd(1'b0, 25'h000102, pat(25'h000102), 1'b0, 4'h2);
    rd(1'b0, 25'h000100, pat(25'h000100), 1'b0, 4'h2);
  endtask
  task automatic t_write;
    int c0;
    c0 = n_rd;
    cpu_op(1'b1, 1'b0, 25'h000102, 16'hC3C3);
    chk("write_wait", wt, 1'b1);
    chk("write_no_read", n_rd - c0, 0);
    rd(1'b0, 25'h000102, 16'hC3C3, 1'b1, 4'h2);
    rd(1'b0, 25'h000100, pat(25'h000100), 1'b0, 4'h2);
  endtask
  task automatic t_cfg;
    reg_op(1'b1, CFG_OFFSET, 16'hFFFE);
    reg_op(1'b1, 24'h3A0212, 16'hFFFF);
    reg_op(1'b0, CFG_OFFSET, 16'h0000);
    chk("cfg_read", q, 16'h000E);
    chk("area_fast", {fas, uas, las}, 3'b111);
    reg_op(1'b0, 24'h3A0212, 16'h0000);
    chk("unmapped", q, 16'h0000);
    reg_op(1'b1, CFG_OFFSET, 16'h0000);
  endtask
  task automatic t_ifetch;
    slow = 1'b1;
    rd(1'b1, 25'h000200, pat(25'h000200), 1'b1, 4'h2);
    reg_op(1'b1, CFG_OFFSET, 16'h0001);
    rd(1'b1, 25'h000304, pat(25'h000304), 1'b1, 4'h8);
    rd(1'b1, 25'h00030A, pat(25'h00030A), 1'b0, 4'h0);
    rd(1'b1, 25'h00040C, pat(25'h00040C), 1'b1, 4'h2);
    rd(1'b0, 25'h000500, pat(25'h000500), 1'b1, 4'h2);
    rd(1'b1, 25'h000600, pat(25'h000600), 1'b1, 4'h8);
    rd(1'b1, 25'h000300, pat(25'h000300), 1'b0, 4'h0);
    cpu_op(1'b1, 1'b0, 25'h000306, 16'h1234);
    chk("slot_write_wait", wt, 1'b1);
    rd(1'b1, 25'h000306, 16'h1234, 1'b1, 4'h8);
    rd(1'b0, 25'h000502, pat(25'h000502), 1'b0, 4'h0);
    slow = 1'b0;
  endtask
  // ==========================================================================
  // clock, reset, sequence, watchdog
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, slow, reg_addr_i, reg_wdata_i} = '0;
    cpu_req_i = '0;
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_data;
    t_write;
    t_cfg;
    t_ifetch;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    final_report;
  end
endmodule
